// File: verilog/dps_defines.svh
// Constants of the dual processor power-up sequencer
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_CLK_HZ          25000000
`define DPS_LB_ACTIVE_S     3
`define DPS_LB_PASSIVE_S    7
`define DPS_LANG_WAIT_S     30
`define DPS_OFF_SELECT      4'h0
`define DPS_OFF_LED         4'h4
`define DPS_OFF_CTRL        4'h8
`define DPS_OFF_STATUS      4'hc
`define DPS_SEL_BIT         31
`define DPS_DIAG_RESTART    32'h20040000
`define DPS_MAIN_RESTART    32'h1fc00000
`define DPS_LED_RESET       4'hf
`define DPS_LED_ROM         4'he
`define DPS_LED_POWER       4'hd
`define DPS_LED_IPT         4'hc
`define DPS_LED_DIAG        4'hb
`define DPS_LED_LOOP_ACT    4'h7
`define DPS_LED_DIAG_CON    4'h4
`define DPS_LED_LOOP_PAS    4'h3
`define DPS_LED_MAIN_CON    4'h3
`define DPS_LED_MAIN_BOOT   4'h1
`define DPS_OP_NORMAL       2'h0
`define DPS_OP_MAINT        2'h1
`define DPS_OP_ACTION       2'h2
`define DPS_FN_TEST         1'h0
`define DPS_FN_QUERY        1'h1
`define DPS_CTRL_IPT_DONE   0
`define DPS_CTRL_DIAG_FAIL  1
`define DPS_CTRL_DIAG_DONE  2
`define DPS_CTRL_LANG_ANS   3
`define DPS_CTRL_LVL_LSB    8
`define DPS_RESP_OKAY       2'h0
`define DPS_RESP_SLVERR     2'h2
`endif

// File: verilog/dps_pkg.sv
// Types of the dual processor power-up sequencer
package dps_pkg;
	typedef enum logic [3:0] {
		DPS_RST   = 4'h0,
		DPS_ROM   = 4'h1,
		DPS_PWR   = 4'h3,
		DPS_IPT   = 4'h2,
		DPS_LANG  = 4'h6,
		DPS_DIAG  = 4'h7,
		DPS_HAND  = 4'h5,
		DPS_MAIN  = 4'h4,
		DPS_DCON  = 4'hc,
		DPS_LBA   = 4'hd,
		DPS_LBP   = 4'hf,
		DPS_HANG  = 4'he
	} dps_state_t;

	// Level settings kept by the diagnostic firmware
	typedef struct packed {
		logic bootpath_valid;
		logic bootmode_init;
		logic boot_auto;
		logic multinational_charset;
		logic nv_valid;
	} dps_cfg_t;

	// Pin inputs after the synchroniser
	typedef struct packed {
		logic       power_good;
		logic [1:0] op_sw;
		logic       func_sw;
		logic       serial_err;
		logic       serial_rx;
	} dps_pins_t;
endpackage

// File: verilog/dps_sequencer.sv
// Dual processor power-up sequencer with AXI4-Lite registers
// Functional notes
// - Diag writes one: diag granted away, main runs
// - Main writes zero: main stalled, diag runs
// - Select register is write-only, reads as zero
// - Handover follows select register bit 31
// - Diag starts first; main at its vector
// - Normal: diagnostics, then handover write of one
// - Auto boot mode: boot, else main console
// - Deferred or unset boot mode: main console
// - Failure recorded, diagnostics finish, then maintenance
// - Maintenance switch: diagnostics then diag console
// - Action plus test: loopback right after selftest
// - Active loopback three seconds, code seven
// - Passive loopback seven seconds, code three
// - Serial error or silence: hang at seven
// - Language query on charset and invalid/query
// - No answer in thirty seconds: US English
// - After query diagnostics decide normal or maintenance
// - LED code set before each step begins
// - LED codes count down F to 1
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "dps_defines.svh"
module dps_sequencer
	import dps_pkg::*;
#(
	parameter int LB_ACTIVE_CYC  = `DPS_LB_ACTIVE_S * `DPS_CLK_HZ,
	parameter int LB_PASSIVE_CYC = `DPS_LB_PASSIVE_S * `DPS_CLK_HZ,
	parameter int LANG_WAIT_CYC  = `DPS_LANG_WAIT_S * `DPS_CLK_HZ
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        power_good,
	input  wire logic [1:0]  op_switch,
	input  wire logic        func_switch,
	input  wire logic        serial_error,
	input  wire logic        serial_rx_char,
	output var  logic        diag_dma_grant,
	output var  logic        main_read_stall,
	output var  logic        main_write_stall,
	output var  logic [31:0] diag_start_addr,
	output var  logic [31:0] main_start_addr,
	output var  logic [3:0]  led_code,
	output var  logic        loopback_tx_en,
	output var  logic        lang_defaulted
);
	localparam int PW = 6;

	dps_state_t      state_reg;
	dps_state_t      state_next;
	dps_cfg_t        cfg_reg;
	dps_pins_t       pins;
	logic [PW-1:0]   sync1_reg;
	logic [PW-1:0]   sync2_reg;
	logic [31:0]     timer_reg;
	logic            sel_reg;
	logic            fail_reg;
	logic            rx_seen_reg;
	logic            aw_held_reg;
	logic            w_held_reg;
	logic [3:0]      waddr_reg;
	logic [31:0]     wdata_reg;
	logic [3:0]      wstrb_reg;
	logic            wr_fire;
	logic            mapped_w;
	logic            ev_ipt;
	logic            ev_fail;
	logic            ev_done;
	logic            ev_lang;
	logic            sel_wr;
	logic            diag_owner;
	logic            main_owner;
	logic            want_lang;
	logic            is_action;

	// Two-flop synchroniser for every pin
	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= (gi == 5) ? power_good :
						(gi == 4) ? op_switch[1] :
						(gi == 3) ? op_switch[0] :
						(gi == 2) ? func_switch :
						(gi == 1) ? serial_error : serial_rx_char;
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate
	assign pins = sync2_reg;

	// Write address and data are taken in either order
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign mapped_w = (waddr_reg == `DPS_OFF_SELECT) || (waddr_reg == `DPS_OFF_LED) ||
		(waddr_reg == `DPS_OFF_CTRL);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DPS_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				waddr_reg <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped_w ? `DPS_RESP_OKAY : `DPS_RESP_SLVERR;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Register write effects
	assign sel_wr = wr_fire && (waddr_reg == `DPS_OFF_SELECT) && wstrb_reg[3];
	assign ev_ipt = wr_fire && (waddr_reg == `DPS_OFF_CTRL) && wstrb_reg[0] &&
		wdata_reg[`DPS_CTRL_IPT_DONE];
	assign ev_fail = wr_fire && (waddr_reg == `DPS_OFF_CTRL) && wstrb_reg[0] &&
		wdata_reg[`DPS_CTRL_DIAG_FAIL];
	assign ev_done = wr_fire && (waddr_reg == `DPS_OFF_CTRL) && wstrb_reg[0] &&
		wdata_reg[`DPS_CTRL_DIAG_DONE];
	assign ev_lang = wr_fire && (waddr_reg == `DPS_OFF_CTRL) && wstrb_reg[0] &&
		wdata_reg[`DPS_CTRL_LANG_ANS];
	assign diag_owner = (state_reg == DPS_HAND) || (state_reg == DPS_DCON);
	assign main_owner = (state_reg == DPS_MAIN);
	assign is_action = (pins.op_sw == `DPS_OP_ACTION);
	assign want_lang = cfg_reg.multinational_charset &&
		(!cfg_reg.nv_valid || (is_action && pins.func_sw == `DPS_FN_QUERY));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg_reg <= '0;
		else if (wr_fire && (waddr_reg == `DPS_OFF_CTRL) && wstrb_reg[1])
			cfg_reg <= wdata_reg[`DPS_CTRL_LVL_LSB +: 5];
	end

	// Read side; select register reads as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `DPS_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `DPS_RESP_OKAY;
				case ({s_axi_araddr[3:2], 2'h0})
					`DPS_OFF_SELECT: s_axi_rdata <= 32'h0;
					`DPS_OFF_LED:    s_axi_rdata <= {28'h0, led_code};
					`DPS_OFF_CTRL:   s_axi_rdata <= {19'h0, cfg_reg, 8'h0};
					`DPS_OFF_STATUS: s_axi_rdata <= {24'h0, lang_defaulted, fail_reg,
						sel_reg, rx_seen_reg, state_reg};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `DPS_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			DPS_RST:  state_next = DPS_ROM;
			DPS_ROM:  state_next = DPS_PWR;
			DPS_PWR:  if (pins.power_good) state_next = DPS_IPT;
			DPS_IPT:
			begin
				if (ev_ipt && is_action && pins.func_sw == `DPS_FN_TEST)
					state_next = DPS_LBA;
				else if (ev_ipt)
					state_next = want_lang ? DPS_LANG : DPS_DIAG;
			end
			DPS_LBA:
			begin
				if (pins.serial_err)
					state_next = DPS_HANG;
				else if (timer_reg == 32'(LB_ACTIVE_CYC - 1))
				begin
					if (!rx_seen_reg)
						state_next = DPS_HANG;
					else if (!is_action)
						state_next = want_lang ? DPS_LANG : DPS_DIAG;
					else
						state_next = DPS_LBP;
				end
			end
			DPS_LBP:
			begin
				if (pins.serial_err)
					state_next = DPS_HANG;
				else if (timer_reg == 32'(LB_PASSIVE_CYC - 1))
					state_next = DPS_LBA;
			end
			DPS_LANG:
			begin
				if (ev_lang || timer_reg == 32'(LANG_WAIT_CYC - 1))
					state_next = DPS_DIAG;
			end
			DPS_DIAG:
			begin
				if (ev_done)
					state_next = (fail_reg || ev_fail || pins.op_sw == `DPS_OP_MAINT) ?
						DPS_DCON : DPS_HAND;
			end
			DPS_HAND: if (sel_wr && wdata_reg[`DPS_SEL_BIT]) state_next = DPS_MAIN;
			DPS_DCON: if (sel_wr && wdata_reg[`DPS_SEL_BIT]) state_next = DPS_MAIN;
			DPS_MAIN: if (sel_wr && !wdata_reg[`DPS_SEL_BIT]) state_next = DPS_DCON;
			DPS_HANG: state_next = DPS_HANG;
			default:  state_next = DPS_RST;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= DPS_RST;
			timer_reg <= 32'h0;
		end
		else
		begin
			state_reg <= state_next;
			timer_reg <= (state_next != state_reg) ? 32'h0 : timer_reg + 32'h1;
		end
	end

	// Failure is sticky until the next selftest; a set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fail_reg <= 1'b0;
		else if (ev_fail && state_reg == DPS_DIAG)
			fail_reg <= 1'b1;
		else if (state_reg == DPS_IPT)
			fail_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_seen_reg <= 1'b0;
			loopback_tx_en <= 1'b0;
			lang_defaulted <= 1'b0;
		end
		else
		begin
			if (state_next == DPS_LBA && state_reg != DPS_LBA)
				rx_seen_reg <= 1'b0;
			else if (state_reg == DPS_LBA && pins.serial_rx)
				rx_seen_reg <= 1'b1;
			loopback_tx_en <= (state_next == DPS_LBA);
			if (state_reg == DPS_LANG && state_next == DPS_DIAG && !ev_lang)
				lang_defaulted <= 1'b1;
			else if (state_reg == DPS_LANG && ev_lang)
				lang_defaulted <= 1'b0;
		end
	end

	// Processor select and stalls follow the owning state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_reg <= 1'b0;
			diag_dma_grant <= 1'b0;
			main_read_stall <= 1'b1;
			main_write_stall <= 1'b1;
			diag_start_addr <= `DPS_DIAG_RESTART;
			main_start_addr <= `DPS_MAIN_RESTART;
		end
		else
		begin
			// diag first, main only once released
			sel_reg <= (state_next == DPS_MAIN);
			diag_dma_grant <= (state_next == DPS_MAIN);
			main_read_stall <= (state_next != DPS_MAIN);
			main_write_stall <= (state_next != DPS_MAIN);
		end
	end

	// code set on entry, before the step runs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			led_code <= `DPS_LED_RESET;
		else if (state_next != state_reg)
		begin
			case (state_next)
				DPS_ROM:  led_code <= `DPS_LED_ROM;
				DPS_PWR:  led_code <= `DPS_LED_POWER;
				DPS_IPT:  led_code <= `DPS_LED_IPT;
				DPS_LANG: led_code <= `DPS_LED_IPT;
				DPS_DIAG: led_code <= `DPS_LED_DIAG;
				DPS_LBA:  led_code <= `DPS_LED_LOOP_ACT;
				DPS_LBP:  led_code <= `DPS_LED_LOOP_PAS;
				DPS_HANG: led_code <= `DPS_LED_LOOP_ACT;
				DPS_DCON: led_code <= `DPS_LED_DIAG_CON;
				DPS_HAND: led_code <= `DPS_LED_DIAG;
				DPS_MAIN: led_code <= (cfg_reg.boot_auto && cfg_reg.bootmode_init &&
					cfg_reg.bootpath_valid) ? `DPS_LED_MAIN_BOOT : `DPS_LED_MAIN_CON;
				default:  led_code <= `DPS_LED_RESET;
			endcase
		end
		else if (wr_fire && waddr_reg == `DPS_OFF_LED && wstrb_reg[0] &&
			(diag_owner || main_owner))
			led_code <= wdata_reg[3:0];
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_grant_on_one: assert property (
		(state_reg == DPS_HAND && sel_wr && wdata_reg[31])
		|=> ##1 (diag_dma_grant && !main_read_stall))
		else $error("grant not given after select one");
	a_stall_on_zero: assert property (
		(state_reg == DPS_MAIN && sel_wr && !wdata_reg[31])
		|=> ##1 (main_read_stall && main_write_stall && !diag_dma_grant))
		else $error("main not stalled after select zero");
	a_sel_reads_zero: assert property (
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h0)
		|=> (s_axi_rvalid && s_axi_rdata == 32'h0))
		else $error("select register read not zero");
	a_grant_exclusive: assert property (!(diag_dma_grant && main_read_stall))
		else $error("both processors stalled");
	a_no_skip_diag: assert property ((state_reg == DPS_MAIN) |-> fail_reg == 1'b0 ||
		$past(state_reg) == DPS_MAIN || $past(state_reg) == DPS_DCON)
		else $error("main entered after failure");
	a_loop_active_led: assert property (
		(state_reg != DPS_LBA && state_next == DPS_LBA)
		|=> (led_code == 4'h7) [*2])
		else $error("active loopback code wrong");
	a_loop_passive_led: assert property (
		(state_reg == DPS_LBA && state_next == DPS_LBP)
		|=> led_code == 4'h3)
		else $error("passive loopback code wrong");
	a_hang_stays: assert property (
		(state_reg == DPS_HANG) |=> (state_reg == DPS_HANG && led_code == 4'h7))
		else $error("hang state left");
	a_led_reset: assert property ($rose(aresetn) |-> led_code == 4'hf)
		else $error("code not all ones after reset");
endmodule
`default_nettype wire

// File: verif/dps_cpu_model.sv
// Bus master model of the two processors
`timescale 1ns/1ns
`default_nettype none
module dps_cpu_model
(
	input  wire logic        aclk,
	output var  logic [3:0]  awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic [3:0]  wstrb,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	output var  logic        bready,
	output var  logic [3:0]  araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	output var  logic        rready
);
	initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw;
		logic wd;
		aw = 0;
		wd = 0;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		while (!(aw && wd))
		begin
			@(posedge aclk);
			if (awready && !aw)
			begin
				aw = 1;
				awvalid <= 1'b0;
				// Released lines must not keep the old value
				awaddr <= ~a;
			end
			if (wready && !wd)
			begin
				wd = 1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		aw = 0;
		while (!aw)
		begin
			@(posedge aclk);
			aw = bvalid;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		logic got;
		got = 0;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		while (!got)
		begin
			@(posedge aclk);
			got = arready;
		end
		arvalid <= 1'b0;
		araddr <= ~a;
		got = 0;
		while (!got)
		begin
			@(posedge aclk);
			got = rvalid;
		end
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verif/dps_sequencer_tb_top.sv
// Self-checking bench of the power-up sequencer
`timescale 1ns/1ns
`default_nettype none
module dps_sequencer_tb_top
	import dps_pkg::*;
;
	localparam int LBA = 20;
	localparam int LBP = 40;
	localparam int LNG = 60;
	logic        aclk, aresetn;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, led_code;
	logic [31:0] s_axi_wdata, s_axi_rdata, diag_start_addr, main_start_addr, v;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, diag_dma_grant, main_read_stall;
	logic        main_write_stall, loopback_tx_en, lang_defaulted;
	dps_pins_t   pins;
	logic [1:0]  bq[$];
	logic [31:0] rq[$];
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	dps_sequencer #(.LB_ACTIVE_CYC(LBA), .LB_PASSIVE_CYC(LBP), .LANG_WAIT_CYC(LNG)) dut_u (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_good(pins.power_good),
		.op_switch(pins.op_sw), .func_switch(pins.func_sw), .serial_error(pins.serial_err),
		.serial_rx_char(pins.serial_rx), .diag_dma_grant, .main_read_stall,
		.main_write_stall, .diag_start_addr, .main_start_addr, .led_code,
		.loopback_tx_en, .lang_defaulted);
	dps_cpu_model cpu_u (.aclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
		.awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid), .wready(s_axi_wready), .bvalid(s_axi_bvalid),
		.bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
		.arready(s_axi_arready), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wait_led(input logic [3:0] c);
		int i;
		i = 0;
		while (led_code !== c && i < 200)
		begin
			@(posedge aclk);
			i++;
		end
		chk(led_code, c);
	endtask
	task automatic hold(input logic [3:0] c, input int n);
		repeat (n)
		begin
			@(posedge aclk);
			chk(led_code, c);
		end
	endtask
	task automatic w(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		bq.push_back(e);
		cpu_u.wr(a, d, s);
	endtask
	task automatic r(input logic [3:0] a, input logic [31:0] e);
		rq.push_back(e);
		cpu_u.rd(a);
	endtask
	// Reset, power wait, selftest and its end
	task automatic start(input logic [1:0] op, input logic fn, input dps_cfg_t cfg);
		aresetn <= 1'b0;
		pins <= {1'b0, op, fn, 2'h0};
		tick(2);
		chk({led_code, main_read_stall, main_write_stall, diag_dma_grant}, 7'h7e);
		chk(diag_start_addr, 32'h20040000);
		chk(main_start_addr, 32'h1fc00000);
		aresetn <= 1'b1;
		wait_led(4'hd);
		hold(4'hd, 5);
		pins.power_good <= 1'b1;
		wait_led(4'hc);
		w(4'h8, {19'h0, cfg, 8'h0}, 4'h2, 2'h0);
		w(4'h8, 32'h1, 4'h1, 2'h0);
	endtask
	// Normal or maintenance path up to the owner after diagnostics
	task automatic boot(input logic [1:0] op, input dps_cfg_t cfg, input logic [3:0] ctl,
		input logic [3:0] led);
		start(op, 1'b0, cfg);
		wait_led(4'hb);
		w(4'h8, {28'h0, ctl}, 4'h1, 2'h0);
		if (led == 4'h4)
		begin
			wait_led(4'h4);
			tick(4);
			chk(diag_dma_grant, 1'b0);
		end
		else
		begin
			w(4'h0, 32'h1, 4'hf, 2'h0);
			tick(3);
			chk(diag_dma_grant, 1'b0);
			w(4'h0, 32'h80000000, 4'h8, 2'h0);
			tick(3);
			chk({diag_dma_grant, main_read_stall, main_write_stall}, 3'h4);
			chk(led_code, led);
		end
		$display("test done op %0d led %h", op, led);
	endtask
	always @(posedge aclk)
	begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bq.size() > 0)
			chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0)
			chk(s_axi_rdata, rq.pop_front());
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			chk({30'h0, s_axi_rresp}, 32'h0);
	end
	// Hang guard; the run needs under a thousand cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		aresetn = 1'b0;
		pins = '0;
		v = $urandom(60191);
		boot(2'h0, 5'h1d, 4'h4, 4'h1);
		r(4'hc, 32'h24);
		r(4'h0, 32'h0);
		w(4'hc, 32'h0, 4'hf, 2'h2);
		repeat (3)
		begin
			v = $urandom;
			w(4'h4, v, 4'h1, 2'h0);
			tick(2);
			chk(led_code, v[3:0]);
		end
		w(4'h0, 32'h0, 4'h8, 2'h0);
		tick(3);
		chk({diag_dma_grant, main_read_stall, main_write_stall}, 3'h3);
		boot(2'h0, 5'h09, 4'h4, 4'h3);
		boot(2'h0, 5'h05, 4'h4, 4'h3);
		boot(2'h0, 5'h0d, 4'h4, 4'h3);
		boot(2'h0, 5'h1d, 4'h6, 4'h4);
		boot(2'h1, 5'h1d, 4'h4, 4'h4);
		start(2'h2, 1'b0, 5'h01);
		wait_led(4'h7);
		pins.serial_rx <= 1'b1;
		hold(4'h7, LBA - 4);
		chk(loopback_tx_en, 1'b1);
		pins.serial_rx <= 1'b0;
		wait_led(4'h3);
		hold(4'h3, LBP - 4);
		wait_led(4'h7);
		hold(4'h7, LBA + LBP);
		r(4'hc, 32'h0e);
		chk(loopback_tx_en, 1'b0);
		$display("test done silent loopback");
		start(2'h2, 1'b0, 5'h01);
		wait_led(4'h7);
		{pins.serial_rx, pins.serial_err} <= 2'h3;
		hold(4'h7, LBA + LBP);
		$display("test done loopback error");
		start(2'h2, 1'b0, 5'h01);
		wait_led(4'h7);
		{pins.serial_rx, pins.op_sw} <= 3'h4;
		wait_led(4'hb);
		$display("test done loopback exit");
		start(2'h0, 1'b0, 5'h02);
		hold(4'hc, LNG - 10);
		chk(lang_defaulted, 1'b0);
		wait_led(4'hb);
		chk(lang_defaulted, 1'b1);
		w(4'h8, 32'h4, 4'h1, 2'h0);
		tick(3);
		r(4'hc, 32'h85);
		start(2'h2, 1'b1, 5'h03);
		tick(5);
		chk(led_code, 4'hc);
		w(4'h8, 32'h8, 4'h1, 2'h0);
		wait_led(4'hb);
		chk(lang_defaulted, 1'b0);
		w(4'h8, 32'h2, 4'h1, 2'h0);
		w(4'h8, 32'h4, 4'h1, 2'h0);
		wait_led(4'h4);
		r(4'hc, 32'h4c);
		$display("test done language");
		give_verdict();
	end
endmodule
`default_nettype wire
